// ==== hdl/uws_pkg.sv ====
// package for the user waveform store: sizes, limits, commands, carriers
package uws_pkg;
  localparam int unsigned SLOT_COUNT = 16;
  localparam int unsigned SLOT_WORDS = 4096;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned SLOT_AW = 4;
  localparam int unsigned WORD_AW = 12;
  localparam logic signed [15:0] SAMPLE_POS_LIMIT = 16'sh7FFF;
  localparam logic signed [15:0] SAMPLE_NEG_LIMIT = -16'sh7FFF;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [3:0] SLOT_SINE_POS = 4'h2;
  localparam logic [3:0] SLOT_SINE_NEG = 4'h3;
  localparam logic [3:0] SLOT_STEP_D1 = 4'h8;
  localparam logic [3:0] SLOT_STEP_D2 = 4'h9;
  localparam logic [3:0] SLOT_STEP_D7 = 4'hA;
  localparam logic [3:0] SLOT_LAST = 4'hF;
  localparam logic [11:0] WORD_LAST = 12'hFFF;

  // host command codes
  typedef enum logic [1:0] {
    UWS_CMD_WRITE = 2'h0,
    UWS_CMD_DELETE = 2'h1,
    UWS_CMD_DELETE_ALL = 2'h2,
    UWS_CMD_IMPORT = 2'h3
  } uws_cmd_t;

  // one host request as it travels through the fifo
  typedef struct packed {
    uws_cmd_t cmd;
    logic [3:0] slot;
    logic [3:0] src_slot;
    logic [11:0] word;
    logic signed [16:0] sample;
  } uws_req_t;

  // playback output sample with its address
  typedef struct packed {
    logic [3:0] slot;
    logic [11:0] word;
    logic signed [15:0] sample;
  } uws_play_t;
endpackage : uws_pkg

// ==== hdl/uws_fifo.sv ====
// the request fifo module is declared in uws_store.sv, beside the store that uses it

// ==== hdl/uws_store.sv ====
// user waveform store: sixteen slots, host loading, defaults, playback
// Contract
// - sixteen independently addressable waveform slots
// - each slot holds 4096 sample words
// - samples are signed 16-bit two's complement
// - clip above positive limit to limit
// - clip below negative limit to limit
// - refuse slot changes while output enabled
// - only host usb path writes slots
// - selection chooses playback slot once confirmed
// - slots nine to eleven hold step responses
// - delete reloads one slot's default
// - delete-all reloads every slot's default
// - import only into its own slot
// - output scales linearly with sample value
// - slots three, four hold sine half-cycles
`timescale 1ns/1ps
module uws_store #(
  parameter int unsigned SLOTS = uws_pkg::SLOT_COUNT,
  parameter int unsigned WORDS = uws_pkg::SLOT_WORDS,
  parameter int unsigned DEPTH = uws_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_valid,
  output logic req_ready,
  input wire uws_pkg::uws_req_t req,
  output logic rsp_valid,
  output logic rsp_refused,
  input wire logic output_en,
  input wire logic [3:0] sel_slot,
  input wire logic sel_confirm,
  input wire logic play_step,
  output uws_pkg::uws_play_t play,
  output logic play_valid,
  output logic busy
);
  // idle drains host requests; fill writes one default word a cycle
  typedef enum {ST_IDLE, ST_FILL} uws_state_t;

  localparam int unsigned MEM_AW = uws_pkg::SLOT_AW + uws_pkg::WORD_AW;

  logic signed [15:0] mem_q [SLOTS*WORDS]; // all slots in one array
  uws_state_t state_q;
  logic [3:0] fill_slot_q; // slot being restored
  logic [11:0] fill_word_q; // word being restored
  logic fill_all_q; // restore continues through every slot
  logic [3:0] play_slot_q; // confirmed playback slot
  logic [11:0] play_word_q; // playback read address
  logic rsp_valid_q;
  logic rsp_refused_q;
  logic play_valid_q;
  uws_pkg::uws_play_t play_q;
  logic busy_q;
  // two-flop synchronisers for the pin-side controls
  logic output_en_s1_q; // first sync stage
  logic output_en_q; // synchronised output enable
  logic confirm_s1_q;
  logic confirm_q;
  logic [3:0] sel_s1_q;
  logic [3:0] sel_q;
  logic step_s1_q;
  logic step_q;
  logic step_d_q; // previous step level for edge detect

  // request path out of the fifo and the single write port
  uws_pkg::uws_req_t fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic signed [15:0] mem_wd;

  // clip a wide incoming value into the legal range; -32768 is never kept
  function automatic logic signed [15:0] clip_sample(input logic signed [16:0] v);
    if (v > 17'(signed'(uws_pkg::SAMPLE_POS_LIMIT))) begin
      clip_sample = uws_pkg::SAMPLE_POS_LIMIT;
    end else if (v < 17'(signed'(uws_pkg::SAMPLE_NEG_LIMIT))) begin
      clip_sample = uws_pkg::SAMPLE_NEG_LIMIT;
    end else begin
      clip_sample = v[15:0];
    end
  endfunction : clip_sample

  // default shape generator; cheap piecewise forms, not exact curves
  function automatic logic signed [15:0] default_word(input logic [3:0] s, input logic [11:0] w);
    logic [11:0] tri_v;
    logic [15:0] mag;
    tri_v = w[11] ? ~w : w;
    mag = {1'b0, tri_v[10:0], 4'h0};
    default_word = 16'sh0000;
    case (s)
      4'h0: default_word = signed'({~w[11], w[10:0], 4'h0}) ;
      4'h1: default_word = signed'({w[11], ~w[10:0], 4'h0});
      uws_pkg::SLOT_SINE_POS: default_word = signed'(mag);
      uws_pkg::SLOT_SINE_NEG: default_word = -signed'(mag);
      uws_pkg::SLOT_STEP_D1, uws_pkg::SLOT_STEP_D2, uws_pkg::SLOT_STEP_D7: begin
        // overshoot shrinks with damping; flat settle after first half
        if (w[11:10] == 2'h0) begin
          default_word = signed'({1'b0, w[9:0], 5'h00});
        end else if (w[11:10] == 2'h1) begin
          default_word = (s == uws_pkg::SLOT_STEP_D1) ? 16'sh7000 :
                         (s == uws_pkg::SLOT_STEP_D2) ? 16'sh6800 : 16'sh6000;
        end else begin
          default_word = 16'sh6000;
        end
      end
      default: default_word = signed'(w[11] ? 16'h0000 : mag);
    endcase
    // plain ramps reach the most negative code, which a slot never keeps
    if (default_word == 16'sh8000) begin
      default_word = uws_pkg::SAMPLE_NEG_LIMIT;
    end
  endfunction : default_word

  // request fifo keeps usb bursts from stalling on restore sweeps
  uws_fifo #(
    .WIDTH($bits(uws_pkg::uws_req_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // requests are drained only when no restore sweep is running
  assign fifo_pop = fifo_valid && (state_q == ST_IDLE);

  // pin-side inputs pass two flops first
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      output_en_s1_q <= 1'b0;
      output_en_q <= 1'b0;
      confirm_s1_q <= 1'b0;
      confirm_q <= 1'b0;
      sel_s1_q <= 4'h0;
      sel_q <= 4'h0;
      step_s1_q <= 1'b0;
      step_q <= 1'b0;
      step_d_q <= 1'b0;
    end else begin
      output_en_s1_q <= output_en;
      output_en_q <= output_en_s1_q;
      confirm_s1_q <= sel_confirm;
      confirm_q <= confirm_s1_q;
      sel_s1_q <= sel_slot;
      sel_q <= sel_s1_q;
      step_s1_q <= play_step;
      step_q <= step_s1_q;
      step_d_q <= step_q;
    end
  end

  // memory write port: host writes or restore sweep (the only write paths)
  always_comb begin
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 16'sh0000;
    if (state_q == ST_FILL) begin
      mem_we = 1'b1;
      mem_wa = {fill_slot_q, fill_word_q};
      mem_wd = default_word(fill_slot_q, fill_word_q);
    end else if (fifo_pop && !output_en_q) begin
      if (fifo_data.cmd == uws_pkg::UWS_CMD_WRITE ||
          (fifo_data.cmd == uws_pkg::UWS_CMD_IMPORT && fifo_data.src_slot == fifo_data.slot)) begin
        mem_we = 1'b1;
        mem_wa = {fifo_data.slot, fifo_data.word};
        mem_wd = clip_sample(fifo_data.sample);
      end
    end
  end

  // sample storage
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // restore sweep control
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
      fill_slot_q <= 4'h0;
      fill_word_q <= 12'h000;
      fill_all_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (fifo_pop && !output_en_q) begin
            if (fifo_data.cmd == uws_pkg::UWS_CMD_DELETE) begin
              state_q <= ST_FILL;
              fill_slot_q <= fifo_data.slot;
              fill_word_q <= 12'h000;
              fill_all_q <= 1'b0;
            end else if (fifo_data.cmd == uws_pkg::UWS_CMD_DELETE_ALL) begin
              state_q <= ST_FILL;
              fill_slot_q <= 4'h0;
              fill_word_q <= 12'h000;
              fill_all_q <= 1'b1;
            end
          end
        end
        ST_FILL: begin
          // one word per cycle; restoring every slot takes 65536 cycles
          fill_word_q <= fill_word_q + 12'h001;
          if (fill_word_q == uws_pkg::WORD_LAST) begin
            if (fill_all_q && fill_slot_q != uws_pkg::SLOT_LAST) begin
              fill_slot_q <= fill_slot_q + 4'h1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // one-cycle answer per drained request
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_valid_q <= 1'b0;
      rsp_refused_q <= 1'b0;
    end else begin
      // refusal is judged on the synchronised enable seen at drain time
      rsp_valid_q <= fifo_pop;
      rsp_refused_q <= fifo_pop && (output_en_q ||
        (fifo_data.cmd == uws_pkg::UWS_CMD_IMPORT && fifo_data.src_slot != fifo_data.slot));
    end
  end

  // slot selection takes effect on confirm only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      play_slot_q <= 4'h0;
    end else if (confirm_q) begin
      play_slot_q <= sel_q;
    end
  end

  // playback address walks the slot and wraps; restarts on new selection
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      play_word_q <= 12'h000;
    end else if (confirm_q) begin
      play_word_q <= 12'h000;
    end else if (step_q && !step_d_q) begin
      play_word_q <= play_word_q + 12'h001;
    end
  end

  // playback sample; passed unscaled so amplitude stays linear in value
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      play_q <= '0;
      play_valid_q <= 1'b0;
    end else begin
      // memory read is registered, so play lags the address by one cycle
      play_q.slot <= play_slot_q;
      play_q.word <= play_word_q;
      play_q.sample <= mem_q[{play_slot_q, play_word_q}];
      play_valid_q <= output_en_q;
    end
  end

  // busy while a restore sweep runs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q == ST_FILL);
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_refused = rsp_refused_q;
  assign play = play_q;
  assign play_valid = play_valid_q;
  assign busy = busy_q;
endmodule : uws_store

// parameterised valid/ready fifo for host requests
module uws_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // one spare pointer bit tells full from empty
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage
  logic [AW:0] wr_q; // write pointer with wrap bit
  logic [AW:0] rd_q; // read pointer with wrap bit
  logic [AW:0] wr_d; // write pointer after this edge
  logic [AW:0] rd_d; // read pointer after this edge
  logic ready_q; // registered not-full, so ready never glitches on a port
  logic push;
  logic pop;

  // ready comes from a flop; valid and data are read on the same clock inside the store
  assign in_ready = ready_q;
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // next pointers feed both the pointer flops and the ready flop
  assign wr_d = push ? wr_q + 1'b1 : wr_q;
  assign rd_d = pop ? rd_q + 1'b1 : rd_q;

  // storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers and the registered not-full flag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      ready_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      // full when the next pointers differ only in the wrap bit
      ready_q <= (wr_d[AW-1:0] != rd_d[AW-1:0]) || (wr_d[AW] == rd_d[AW]);
    end
  end
endmodule : uws_fifo

// ==== sim/uws_store_props.sv ====
// checker for the user waveform store ports
`timescale 1ns/1ps
module uws_store_props #(
  parameter int unsigned SLOTS = 16,
  parameter int unsigned WORDS = 4096,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire uws_pkg::uws_req_t req,
  input wire logic rsp_valid,
  input wire logic rsp_refused,
  input wire logic output_en,
  input wire logic [3:0] sel_slot,
  input wire logic sel_confirm,
  input wire logic play_step,
  input wire uws_pkg::uws_play_t play,
  input wire logic play_valid,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // output enable held long enough to pass the synchroniser
  sequence s_en_on; output_en[*4]; endsequence
  sequence s_en_off; !output_en[*4]; endsequence
  a_refuse_has_rsp: assert property (rsp_refused |-> rsp_valid)
    else $error("refusal without response");
  a_ready_after_reset: assert property ($past(srst) |-> req_ready)
    else $error("fifo not ready after reset");
  a_min_code_never: assert property (play_valid |-> play.sample != 16'sh8000)
    else $error("most negative code played");
  a_sel_follows: assert property ((sel_confirm && $stable(sel_slot))[*6] |-> play.slot == sel_slot)
    else $error("played slot not the chosen one");
  a_word_steps: assert property (!$stable(play.word) |->
    (play.word == 12'($past(play.word) + 12'h1)) || (play.word == 12'h000))
    else $error("play address jumped");
  a_sweep_quiet: assert property (busy |-> !rsp_valid)
    else $error("response during restore sweep");
  a_refuse_when_on: assert property (s_en_on ##1 (output_en && rsp_valid) |-> rsp_refused)
    else $error("change accepted with output on");
  a_play_on: assert property (s_en_on |-> play_valid)
    else $error("playback not valid");
  a_play_off: assert property (s_en_off |-> !play_valid)
    else $error("playback valid with output off");
endmodule : uws_store_props

bind uws_store uws_store_props #(.SLOTS(SLOTS), .WORDS(WORDS), .DEPTH(DEPTH)) u_uws_store_props (
  .clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .output_en(output_en), .sel_slot(sel_slot),
  .sel_confirm(sel_confirm), .play_step(play_step), .play(play), .play_valid(play_valid), .busy(busy));

// ==== sim/uws_host_model.sv ====
// host side model: the only path that pushes requests into the store
`timescale 1ns/1ps
module uws_host_model (
  input wire logic clk_sys,
  input wire logic req_ready,
  output logic req_valid,
  output uws_pkg::uws_req_t req
);
  // idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // hold until the fifo takes it, then scramble the idle bus so stale data never looks valid
  task automatic send(input uws_pkg::uws_req_t r);
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= r;
    // ready is a flop: read it settled, it holds until the edge that takes the request
    #1;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req <= ~r;
    // a full fifo that never drains is a hang
    if (n >= 200) begin
      testbench.errors++;
      testbench.stop_test();
    end
  endtask : send
endmodule : uws_host_model

// ==== sim/testbench.sv ====
// self-checking bench for the user waveform store
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic req_valid;
  logic req_ready;
  uws_pkg::uws_req_t req;
  logic rsp_valid;
  logic rsp_refused;
  logic output_en = 1'b0;
  logic [3:0] sel_slot = 4'h0;
  logic sel_confirm = 1'b0;
  logic play_step = 1'b0;
  uws_pkg::uws_play_t play;
  logic play_valid;
  logic busy;
  int errors = 0;
  int samples_checked = 0;
  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;
  uws_store u_uws_store (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .output_en(output_en),
    .sel_slot(sel_slot), .sel_confirm(sel_confirm), .play_step(play_step), .play(play),
    .play_valid(play_valid), .busy(busy));
  uws_host_model u_uws_host_model (.clk_sys(clk_sys), .req_ready(req_ready), .req_valid(req_valid),
    .req(req));
  // verdict and end of run
  task automatic stop_test();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // one comparison, counted
  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check
  // bounded wait for a flag level, sampled just after the edge
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (sig !== lvl) begin
      check(1'b0, "wait ran out");
      stop_test();
    end
  endtask : wait_for
  // one request and its response flag
  task automatic do_req(input uws_pkg::uws_cmd_t c, input logic [3:0] s, input logic [3:0] src,
    input logic [11:0] w, input logic signed [16:0] v, input logic refused);
    u_uws_host_model.send('{c, s, src, w, v});
    wait_for(rsp_valid, 1'b1, 20);
    check(rsp_refused === refused, "refusal flag wrong");
  endtask : do_req
  // restore sweep must start and finish
  task automatic sweep(input int lim);
    wait_for(busy, 1'b1, 5);
    wait_for(busy, 1'b0, lim);
  endtask : sweep
  // choose a slot and step the address, leaving play settled for a look
  task automatic play_go(input logic [3:0] s, input int steps);
    @(posedge clk_sys);
    sel_slot <= s;
    sel_confirm <= 1'b1;
    repeat (8) @(posedge clk_sys);
    sel_confirm <= 1'b0;
    // steps are slow enough to pass the two-flop synchroniser
    repeat (steps) begin
      repeat (3) @(posedge clk_sys);
      play_step <= 1'b1;
      repeat (3) @(posedge clk_sys);
      play_step <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : play_go
  // compare what plays against an exact value
  task automatic play_at(input logic [3:0] s, input int steps, input logic [15:0] exp);
    logic ok;
    play_go(s, steps);
    ok = play_valid === 1'b1 && play.slot === s && play.word === 12'(steps);
    check(ok && play.sample === exp, "played sample wrong");
  endtask : play_at
  // compare only the sign of a default shape sample
  task automatic play_sign(input logic [3:0] s, input int steps, input logic pos);
    logic ok;
    play_go(s, steps);
    ok = play_valid === 1'b1 && play.slot === s && play.word === 12'(steps);
    check(ok && (pos ? play.sample > 16'sh0000 : play.sample < 16'sh0000), "default shape wrong");
  endtask : play_sign
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    // memory is not reset: restore every slot first
    do_req(uws_pkg::UWS_CMD_DELETE_ALL, 4'h0, 4'h0, 12'h000, 17'sh00000, 1'b0);
    sweep(70000);
    do_req(uws_pkg::UWS_CMD_WRITE, 4'h0, 4'h0, 12'h000, 17'sh08000, 1'b0);
    do_req(uws_pkg::UWS_CMD_WRITE, 4'h0, 4'h0, 12'h001, 17'sh18000, 1'b0);
    do_req(uws_pkg::UWS_CMD_WRITE, 4'h0, 4'h0, 12'h002, 17'sh1FFFF, 1'b0);
    do_req(uws_pkg::UWS_CMD_WRITE, 4'h5, 4'h0, 12'h000, 17'sh00123, 1'b0);
    do_req(uws_pkg::UWS_CMD_IMPORT, 4'h6, 4'h7, 12'h000, 17'sh00456, 1'b1);
    do_req(uws_pkg::UWS_CMD_IMPORT, 4'h6, 4'h6, 12'h000, 17'sh00456, 1'b0);
    do_req(uws_pkg::UWS_CMD_WRITE, 4'h1, 4'h0, 12'h008, -17'sh00005, 1'b0);
    do_req(uws_pkg::UWS_CMD_DELETE, 4'h1, 4'h0, 12'h000, 17'sh00000, 1'b0);
    sweep(5000);
    @(posedge clk_sys);
    output_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    do_req(uws_pkg::UWS_CMD_WRITE, 4'h5, 4'h0, 12'h000, 17'sh00777, 1'b1);
    do_req(uws_pkg::UWS_CMD_DELETE, 4'h5, 4'h0, 12'h000, 17'sh00000, 1'b1);
    play_at(4'h0, 0, 16'h7FFF);
    play_at(4'h0, 1, 16'h8001);
    play_at(4'h0, 2, 16'hFFFF);
    play_at(4'h5, 0, 16'h0123);
    play_at(4'h0, 4096, 16'h7FFF);
    play_sign(4'h1, 8, 1'b1);
    play_sign(uws_pkg::SLOT_SINE_POS, 8, 1'b1);
    play_sign(uws_pkg::SLOT_SINE_NEG, 8, 1'b0);
    play_sign(uws_pkg::SLOT_STEP_D1, 8, 1'b1);
    play_sign(uws_pkg::SLOT_LAST, 8, 1'b1);
    stop_test();
  end
endmodule : testbench
